// ### include/sac_pkg.sv
// Package for the speaker amplifier control register bank.
// Assumes an 8-bit register port with 7-bit page-local addresses.
package sac_pkg;
  // Register offsets within the page
  localparam logic [6:0] SAC_ADDR_ROUTE = 7'h2D;
  localparam logic [6:0] SAC_ADDR_LATT = 7'h2E;
  localparam logic [6:0] SAC_ADDR_RATT = 7'h2F;
  // Field positions
  localparam int SAC_BIT_LROUTE = 7;
  localparam int SAC_BIT_RROUTE = 6;
  localparam int SAC_BIT_MONO = 2;
  localparam int SAC_BIT_LPWR = 1;
  localparam int SAC_BIT_RPWR = 0;
  localparam int SAC_BIT_LINK = 7;
  // Writable masks; other bits are reserved and read zero
  localparam logic [7:0] SAC_MASK_ROUTE = 8'hC7;
  localparam logic [7:0] SAC_MASK_LATT = 8'h7F;
  localparam logic [7:0] SAC_MASK_RATT = 8'hFF;
  // Reset values
  localparam logic [7:0] SAC_RST_ROUTE = 8'h00;
  localparam logic [7:0] SAC_RST_LATT = 8'h7F;
  localparam logic [7:0] SAC_RST_RATT = 8'h7F;
  // Attenuation code meaning "path not routed"
  localparam logic [6:0] SAC_ATT_OFF = 7'h7F;
  // First reserved attenuation code
  localparam logic [6:0] SAC_ATT_RSV_LO = 7'h76;
  // Read data for an unmapped offset
  localparam logic [7:0] SAC_RD_NONE = 8'h00;

  // Register state
  typedef struct packed {
    logic [7:0] route;
    logic [7:0] latt;
    logic [7:0] ratt;
    logic [7:0] rdata;
  } sac_state_s;
endpackage : sac_pkg

// ### rtl/sac_regs.sv
// Speaker amplifier control register bank: routing, mono mode, driver
// power and line-to-speaker attenuation. Assumes a synchronous register
// port on mclk_i; writes are single-cycle strobes.
`timescale 1ns/1ps
module sac_regs
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Register port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Routing and power to the analog drivers
  output logic left_mixer_amp_to_left_o,
  output logic right_mixer_amp_to_right_o,
  output logic right_mixer_amp_to_left_o,
  output logic left_speaker_driver_pwr_o,
  output logic right_speaker_driver_pwr_o,
  output logic mono_mode_o,
  // Line output to speaker attenuation
  output logic [6:0] left_line_atten_o,
  output logic [6:0] right_line_atten_o,
  output logic left_line_output_routed_o,
  output logic right_line_output_routed_o
);
  import sac_pkg::*;

  sac_state_s st_q;
  sac_state_s st_d;
  logic [6:0] ratt_eff;

  // Next state: masked writes and registered read data
  always_comb
  begin
    st_d = st_q;
    if (wr_en_i)
    begin
      case (addr_i)
        SAC_ADDR_ROUTE: st_d.route = wdata_i & SAC_MASK_ROUTE;
        SAC_ADDR_LATT: st_d.latt = wdata_i & SAC_MASK_LATT;
        SAC_ADDR_RATT: st_d.ratt = wdata_i & SAC_MASK_RATT;
        default: st_d.rdata = st_q.rdata;
      endcase
    end
    if (rd_en_i)
    begin
      case (addr_i)
        SAC_ADDR_ROUTE: st_d.rdata = st_q.route;
        SAC_ADDR_LATT: st_d.rdata = st_q.latt;
        SAC_ADDR_RATT: st_d.rdata = st_q.ratt;
        default: st_d.rdata = SAC_RD_NONE;
      endcase
    end
  end

  // State register with documented defaults
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_q.route <= SAC_RST_ROUTE;
      st_q.latt <= SAC_RST_LATT;
      st_q.ratt <= SAC_RST_RATT;
      st_q.rdata <= SAC_RD_NONE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Effective right code under the link bit
  assign ratt_eff = st_q.ratt[SAC_BIT_LINK] ? st_q.latt[6:0] : st_q.ratt[6:0];

  // Driver controls from stored fields; right-to-left routing gated by mono, right code through the link mux
  assign rdata_o = st_q.rdata;
  assign left_mixer_amp_to_left_o = st_q.route[SAC_BIT_LROUTE];
  assign right_mixer_amp_to_right_o = st_q.route[SAC_BIT_RROUTE];
  assign mono_mode_o = st_q.route[SAC_BIT_MONO];
  assign right_mixer_amp_to_left_o = mono_mode_o & st_q.route[SAC_BIT_RROUTE];
  assign left_speaker_driver_pwr_o = st_q.route[SAC_BIT_LPWR];
  assign right_speaker_driver_pwr_o = st_q.route[SAC_BIT_RPWR];
  assign left_line_atten_o = st_q.latt[6:0];
  assign right_line_atten_o = ratt_eff;
  assign left_line_output_routed_o = (st_q.latt[6:0] != SAC_ATT_OFF);
  assign right_line_output_routed_o = (ratt_eff != SAC_ATT_OFF);

  // Reserved route bits never store ones
  AST_RSV_ZERO: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_q.route & ~SAC_MASK_ROUTE) == 8'h00 && !st_q.latt[7])
    else $error("reserved bits not zero");
  // A write to the route register shows on the outputs next cycle
  AST_ROUTE_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_ROUTE) |=> left_mixer_amp_to_left_o == $past(wdata_i[7])
    && right_mixer_amp_to_right_o == $past(wdata_i[6]))
    else $error("routing not updated by write");
  AST_PWR_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_ROUTE) |=> left_speaker_driver_pwr_o == $past(wdata_i[1])
    && right_speaker_driver_pwr_o == $past(wdata_i[0]))
    else $error("driver power not updated by write");
  // Mono mode mirrors right routing to the left driver
  AST_MONO: assert property (@(posedge mclk_i) disable iff (srst_i)
    right_mixer_amp_to_left_o == (mono_mode_o && right_mixer_amp_to_right_o))
    else $error("mono mirroring wrong");
  // Left attenuation write lands next cycle
  AST_LATT_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_LATT) |=> left_line_atten_o == $past(wdata_i[6:0]))
    else $error("left attenuation not updated");
  // Link bit makes right path follow left code
  AST_LINK: assert property (@(posedge mclk_i) disable iff (srst_i)
    st_q.ratt[SAC_BIT_LINK] |-> right_line_atten_o == left_line_atten_o)
    else $error("linked attenuation mismatch");
  // Disconnect codes
  AST_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
    (left_line_output_routed_o == (left_line_atten_o != SAC_ATT_OFF))
    && (right_line_output_routed_o == (right_line_atten_o != SAC_ATT_OFF)))
    else $error("disconnect code handling wrong");
  // Defaults after reset
  AST_RESET: assert property (@(posedge mclk_i)
    $past(srst_i) |-> !left_speaker_driver_pwr_o && !right_speaker_driver_pwr_o
    && !left_line_output_routed_o && !right_line_output_routed_o && !mono_mode_o)
    else $error("reset defaults wrong");
  // Read back returns stored value one cycle later
  AST_READ: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_en_i && !wr_en_i && addr_i == SAC_ADDR_RATT) |=> rdata_o == $past(st_q.ratt))
    else $error("read back mismatch");

  // Mono bit lands with a route write
  AST_MONO_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_ROUTE) |=> mono_mode_o == $past(wdata_i[SAC_BIT_MONO]))
    else $error("mono bit not updated by write");

  // Right power bit lands with a route write
  AST_RPWR_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_ROUTE)
    |=> right_speaker_driver_pwr_o == $past(wdata_i[SAC_BIT_RPWR]))
    else $error("right driver power not updated");

  // Right route bit lands with a route write
  AST_RROUTE_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_ROUTE)
    |=> right_mixer_amp_to_right_o == $past(wdata_i[SAC_BIT_RROUTE]))
    else $error("right routing not updated");

  // Unlinked right write lands on the right code
  AST_RATT_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_RATT && !wdata_i[SAC_BIT_LINK])
    |=> right_line_atten_o == $past(wdata_i[6:0]))
    else $error("right attenuation not updated");

  // Linked right write hands the right path to the left code
  AST_LINK_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en_i && addr_i == SAC_ADDR_RATT && wdata_i[SAC_BIT_LINK])
    |=> right_line_atten_o == $past(left_line_atten_o))
    else $error("link write not applied");

  // Without the link the right path keeps its own code
  AST_UNLINKED: assert property (@(posedge mclk_i) disable iff (srst_i)
    !st_q.ratt[SAC_BIT_LINK] |-> right_line_atten_o == st_q.ratt[6:0])
    else $error("independent right code wrong");

  // Route outputs hold while nothing is written
  AST_HOLD_ROUTE: assert property (@(posedge mclk_i) disable iff (srst_i)
    !wr_en_i |=> $stable(st_q.route))
    else $error("route register changed without write");

  // Attenuation outputs hold while nothing is written
  AST_HOLD_ATT: assert property (@(posedge mclk_i) disable iff (srst_i)
    !wr_en_i |=> $stable(left_line_atten_o) && $stable(right_line_atten_o))
    else $error("attenuation changed without write");

  // Read data holds between reads
  AST_RDATA_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
    !rd_en_i |=> $stable(rdata_o))
    else $error("read data changed without read");

  // Route register reads back with reserved bits clear
  AST_READ_ROUTE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_en_i && addr_i == SAC_ADDR_ROUTE) |=> rdata_o == $past(st_q.route)
    && (rdata_o & ~SAC_MASK_ROUTE) == 8'h00)
    else $error("route read back wrong");

  // Left register reads back with top bit clear
  AST_READ_LATT: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_en_i && addr_i == SAC_ADDR_LATT) |=> rdata_o == $past(st_q.latt) && !rdata_o[7])
    else $error("left read back wrong");

  // Unmapped offsets read as zero
  AST_READ_NONE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_en_i && addr_i != SAC_ADDR_ROUTE && addr_i != SAC_ADDR_LATT
    && addr_i != SAC_ADDR_RATT) |=> rdata_o == SAC_RD_NONE)
    else $error("unmapped read not zero");

  // Left disconnect code drops the left path
  AST_LOFF: assert property (@(posedge mclk_i) disable iff (srst_i)
    left_line_atten_o == SAC_ATT_OFF |-> !left_line_output_routed_o)
    else $error("left disconnect code ignored");

  // Attenuation codes and read data return to defaults on reset
  AST_RESET_ATT: assert property (@(posedge mclk_i)
    $past(srst_i) |-> left_line_atten_o == SAC_ATT_OFF && right_line_atten_o == SAC_ATT_OFF
    && rdata_o == SAC_RD_NONE && !left_mixer_amp_to_left_o && !right_mixer_amp_to_right_o)
    else $error("attenuation reset defaults wrong");
endmodule : sac_regs

// ### sim/speaker_amp_control_regs_tb.sv
// Bench for the speaker amplifier register bank.
// Assumes sac_pkg; the bench drives the register port itself.
`timescale 1ns/1ps
module speaker_amp_control_regs_tb;
  import sac_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [6:0] addr_i = 7'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic lml, rmr, rml, lpw, rpw, mono, lrt, rrt;
  logic [6:0] latt, ratt;
  int errors = 0;
  int n_compared = 0;
  // Outputs packed for comparison, routed flag on top of each attenuation word
  wire [7:0] drv = {2'h0, lml, rmr, rml, mono, lpw, rpw};
  wire [7:0] lat = {lrt, latt};
  wire [7:0] rat = {rrt, ratt};
  sac_regs i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .left_mixer_amp_to_left_o(lml), .right_mixer_amp_to_right_o(rmr),
    .right_mixer_amp_to_left_o(rml), .left_speaker_driver_pwr_o(lpw),
    .right_speaker_driver_pwr_o(rpw), .mono_mode_o(mono),
    .left_line_atten_o(latt), .right_line_atten_o(ratt),
    .left_line_output_routed_o(lrt), .right_line_output_routed_o(rrt));
  // 20 MHz clock
  initial forever #25 mclk_i = ~mclk_i;
  task automatic end_of_test;
    $display("Counts: %0d compared, %0d mismatches", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  // One-cycle strobes, entered 1 ns after an edge, then one idle cycle
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge mclk_i);
    #1 wr_en_i = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    rd_en_i = 1'b1;
    addr_i = a;
    @(posedge mclk_i);
    #1 rd_en_i = 1'b0;
    chk(rdata_o, e, "read");
    @(posedge mclk_i);
    #1;
  endtask : rd
  task automatic t_reset;
    chk(drv, 8'h00, "drv rst");
    chk(lat, 8'h7F, "latt rst");
    chk(rat, 8'h7F, "ratt rst");
    rd(SAC_ADDR_ROUTE, 8'h00);
    rd(SAC_ADDR_LATT, 8'h7F);
    rd(SAC_ADDR_RATT, 8'h7F);
    $display("reset done");
  endtask : t_reset
  task automatic t_route;
    wr(SAC_ADDR_ROUTE, 8'hFF);
    chk(drv, 8'h3F, "all on mono");
    rd(SAC_ADDR_ROUTE, 8'hC7);
    wr(SAC_ADDR_ROUTE, 8'h42);
    chk(drv, 8'h12, "stereo right");
    wr(SAC_ADDR_ROUTE, 8'h85);
    chk(drv, 8'h25, "mono no right");
    $display("route done");
  endtask : t_route
  task automatic t_atten;
    wr(SAC_ADDR_LATT, 8'h80);
    chk(lat, 8'h80, "latt 0 dB");
    rd(SAC_ADDR_LATT, 8'h00);
    wr(SAC_ADDR_LATT, 8'h75);
    chk(lat, 8'hF5, "latt max");
    wr(SAC_ADDR_RATT, 8'h00);
    chk(rat, 8'h80, "ratt 0 dB");
    wr(SAC_ADDR_RATT, 8'h7F);
    chk(rat, 8'h7F, "ratt off");
    wr(SAC_ADDR_LATT, 8'h7F);
    chk(lat, 8'h7F, "latt off");
    $display("atten done");
  endtask : t_atten
  task automatic t_link;
    wr(SAC_ADDR_LATT, 8'h12);
    wr(SAC_ADDR_RATT, 8'hF4);
    chk(rat, 8'h92, "linked");
    rd(SAC_ADDR_RATT, 8'hF4);
    wr(SAC_ADDR_RATT, 8'h74);
    chk(rat, 8'hF4, "independent");
    wr(7'h2C, 8'hFF);
    chk(drv, 8'h25, "unmapped wr");
    rd(7'h30, SAC_RD_NONE);
    $display("link done");
  endtask : t_link
  // Main sequence with a second reset mid-run
  initial
  begin
    repeat (10) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    t_reset;
    t_route;
    t_atten;
    t_link;
    srst_i = 1'b1;
    @(posedge mclk_i);
    #1 srst_i = 1'b0;
    t_reset;
    end_of_test;
  end
endmodule : speaker_amp_control_regs_tb
